// file: core/cfcell_top.sv
/*
  Storage cells 6 to 11 and the four-input table, with their
  configuration held in registers behind an Avalon-MM slave.
  Assumes matrix inputs are synchronous to CLK_SYS and SRST is the
  power-on reset, held at least two edges.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfcell_cfg.svh"

module cfcell_top #(
  parameter logic [`CFCELL_TW-1:0] TABLE_DEFAULT = `CFCELL_RST_TABLE,
  parameter logic [`CFCELL_NCELL-1:0] MODE_DEFAULT = `CFCELL_RST_MODE,
  parameter logic [`CFCELL_NCELL-1:0] POL_DEFAULT = `CFCELL_RST_POL,
  parameter logic [`CFCELL_NSR-1:0] SRSEL_DEFAULT = `CFCELL_RST_SRSEL,
  parameter logic [`CFCELL_NCELL-1:0] INIT_DEFAULT = `CFCELL_RST_INIT
) (
  input wire logic CLK_SYS,                   // System clock
  input wire logic SRST,                      // Power-on reset, high
  input wire cfcell_pkg::cfcell_avreq_t AVS_REQ, // Avalon-MM request
  output logic [`CFCELL_DW-1:0] AVS_READDATA, // Avalon-MM read data
  output logic AVS_WAITREQUEST,               // Avalon-MM stall
  input wire logic [`CFCELL_NCELL-1:0] CELL_DATA, // Matrix data in
  input wire logic [`CFCELL_NCELL-1:0] CELL_GATE, // Matrix clock/enable
  input wire logic [`CFCELL_NSR-1:0] CELL_SR,     // Set/reset, cells 6-8
  output logic [`CFCELL_NCELL-1:0] CELL_OUT,      // Cell outputs
  input wire logic [`CFCELL_SW-1:0] FOUR_INPUT_TABLE_ONE_IN, // Table in
  output logic FOUR_INPUT_TABLE_ONE_OUT          // Table output
);

  cfcell_pkg::cfcell_top_st_t st_ff, nxt_st;
  logic [`CFCELL_NCELL-1:0] cell_stored;
  logic [`CFCELL_NCELL-1:0] cell_drive;
  logic table_pick;
  logic req_any;
  logic [`CFCELL_DW-1:0] wr_word;
  logic [`CFCELL_DW-1:0] rd_word;

  // Byte-lane merge of write data into an old register value
  function automatic logic [`CFCELL_DW-1:0] merge_be(
    input logic [`CFCELL_DW-1:0] old_v,
    input logic [`CFCELL_DW-1:0] new_v,
    input logic [`CFCELL_BEW-1:0] be
  );
    logic [`CFCELL_DW-1:0] res;
    res = old_v;
    for (int b = 0; b < `CFCELL_BEW; b++) begin
      if (be[b]) begin
        res[b*`CFCELL_BYTE +: `CFCELL_BYTE] =
          new_v[b*`CFCELL_BYTE +: `CFCELL_BYTE];
      end
    end
    return res;
  endfunction

  // Register read decode; unmapped offsets read zero
  function automatic logic [`CFCELL_DW-1:0] read_reg(
    input cfcell_pkg::cfcell_top_st_t s,
    input logic [`CFCELL_NCELL-1:0] q,
    input logic [`CFCELL_AW-1:0] addr
  );
    logic [`CFCELL_DW-1:0] v;
    v = '0;
    unique case (addr)
      `CFCELL_OFF_TABLE: v = `CFCELL_DW'(s.table_word);
      `CFCELL_OFF_MODE: v = `CFCELL_DW'(s.mode);
      `CFCELL_OFF_POL: v = `CFCELL_DW'(s.pol);
      `CFCELL_OFF_SRSEL: v = `CFCELL_DW'(s.srsel);
      `CFCELL_OFF_INIT: v = `CFCELL_DW'(s.init);
      `CFCELL_OFF_STATUS: begin
        v[`CFCELL_NCELL-1:0] = s.out;
        v[`CFCELL_STAT_TBIT] = s.table_out;
      end
      `CFCELL_OFF_STORED: v = `CFCELL_DW'(q);
      default: v = '0;
    endcase
    return v;
  endfunction

  // Cells; only the first NSR have the matrix set/reset input
  for (genvar i = 0; i < `CFCELL_NCELL; i++) begin : g_cell
    cfcell_pkg::cfcell_cellcfg_t ccfg;
    logic csr;
    assign ccfg.mode = st_ff.mode[i];
    assign ccfg.pol = st_ff.pol[i];
    assign ccfg.init = st_ff.init[i];
    if (i < `CFCELL_NSR) begin : g_sr
      assign ccfg.srsel = st_ff.srsel[i];
      assign csr = CELL_SR[i];
    end else begin : g_nosr
      // No set/reset here; the select bit is unused and reads zero
      assign ccfg.srsel = 1'b0;
      assign csr = 1'b0;
    end
    cfcell_cell #(
      .HAS_SR(i < `CFCELL_NSR)
    ) u_cell (
      .clk(CLK_SYS),
      .rst(SRST),
      .cfg(ccfg),
      .d(CELL_DATA[i]),
      .gate(CELL_GATE[i]),
      .sr(csr),
      .stored(cell_stored[i]),
      .drive(cell_drive[i])
    );
  end

  // Truth-table lookup
  cfcell_table u_table (
    .truth(st_ff.table_word),
    .sel(FOUR_INPUT_TABLE_ONE_IN),
    .pick(table_pick)
  );

  // Stall every request for one cycle so read data comes from a flop
  assign req_any = AVS_REQ.read || AVS_REQ.write;
  assign AVS_WAITREQUEST = req_any && (st_ff.bus != cfcell_pkg::BUS_ACK);

  // Next state: bus handshake, config writes, registered outputs
  always_comb begin
    nxt_st = st_ff;
    rd_word = read_reg(st_ff, cell_stored, AVS_REQ.address);
    wr_word = '0;
    nxt_st.out = cell_drive;
    nxt_st.table_out = table_pick;
    unique case (st_ff.bus)
      cfcell_pkg::BUS_IDLE: begin
        if (req_any) begin
          nxt_st.bus = cfcell_pkg::BUS_ACK;
          if (AVS_REQ.read) begin
            nxt_st.rdata = rd_word;
          end
        end
      end
      cfcell_pkg::BUS_ACK: begin
        // Write takes effect on the edge that sees waitrequest low
        nxt_st.bus = cfcell_pkg::BUS_IDLE;
        if (AVS_REQ.write) begin
          wr_word = merge_be(rd_word, AVS_REQ.writedata,
                             AVS_REQ.byteenable);
          unique case (AVS_REQ.address)
            `CFCELL_OFF_TABLE: nxt_st.table_word = wr_word[`CFCELL_TW-1:0];
            `CFCELL_OFF_MODE: nxt_st.mode = wr_word[`CFCELL_NCELL-1:0];
            `CFCELL_OFF_POL: nxt_st.pol = wr_word[`CFCELL_NCELL-1:0];
            `CFCELL_OFF_SRSEL: nxt_st.srsel = wr_word[`CFCELL_NSR-1:0];
            `CFCELL_OFF_INIT: nxt_st.init = wr_word[`CFCELL_NCELL-1:0];
            // Status and unmapped offsets ignore writes
            default: nxt_st.rdata = st_ff.rdata;
          endcase
        end
      end
      default: nxt_st.bus = cfcell_pkg::BUS_IDLE;
    endcase
    // Configuration reloads its stored defaults at power-on
    if (SRST) begin
      nxt_st.bus = cfcell_pkg::BUS_IDLE;
      nxt_st.table_word = TABLE_DEFAULT;
      nxt_st.mode = MODE_DEFAULT;
      nxt_st.pol = POL_DEFAULT;
      nxt_st.srsel = SRSEL_DEFAULT;
      nxt_st.init = INIT_DEFAULT;
      nxt_st.rdata = '0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    st_ff <= nxt_st;
  end

  // All data outputs come straight from flops
  assign AVS_READDATA = st_ff.rdata;
  assign CELL_OUT = st_ff.out;
  assign FOUR_INPUT_TABLE_ONE_OUT = st_ff.table_out;

  // Check helpers: a write takes effect, a read loads its data
  logic wr_take;
  logic rd_load;
  logic table_ref;
  assign wr_take = AVS_REQ.write && !AVS_WAITREQUEST;
  assign rd_load = AVS_REQ.read && AVS_WAITREQUEST;
  // Independent of u_table, so a wiring slip there shows up
  assign table_ref = st_ff.table_word[FOUR_INPUT_TABLE_ONE_IN];

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  sequence s_req_wait;
    req_any && AVS_WAITREQUEST;
  endsequence

  sequence s_req_done;
    req_any && !AVS_WAITREQUEST;
  endsequence

  // One wait cycle per request, read data from the flop
  a_bus_answer: assert property (
    s_req_wait |=> s_req_done)
    else $error("request not answered after one wait cycle");
  a_read_value: assert property (
    AVS_REQ.read && AVS_WAITREQUEST
      |=> AVS_READDATA == $past(rd_word))
    else $error("read data differs from register");
  // Cells, table and defaults as seen through the top
  a_mode_write: assert property (
    AVS_REQ.write && !AVS_WAITREQUEST && AVS_REQ.byteenable[0]
      && AVS_REQ.address == `CFCELL_OFF_MODE
      |=> st_ff.mode == $past(AVS_REQ.writedata[`CFCELL_NCELL-1:0]))
    else $error("mode write did not land");
  a_pol_drive: assert property (
    1'b1 |=> (CELL_OUT ^ $past(st_ff.pol)) == $past(cell_stored))
    else $error("cell output polarity wrong");
  a_table_pick: assert property (
    1'b1 |=> FOUR_INPUT_TABLE_ONE_OUT == $past(table_ref))
    else $error("table output is not the selected bit");
  a_por_defaults: assert property (
    $fell(SRST) |-> st_ff.init == INIT_DEFAULT
      && st_ff.mode == MODE_DEFAULT)
    else $error("configuration not at defaults after reset");
  a_unmapped_zero: assert property (
    AVS_REQ.read && AVS_WAITREQUEST
      && AVS_REQ.address > `CFCELL_OFF_STORED
      |=> AVS_READDATA == '0)
    else $error("unmapped offset did not read zero");

  // Each configuration write lands in its own field
  a_pol_write: assert property (
    wr_take && AVS_REQ.byteenable[0] && AVS_REQ.address == `CFCELL_OFF_POL
      |=> st_ff.pol == $past(AVS_REQ.writedata[`CFCELL_NCELL-1:0]))
    else $error("polarity write did not land");
  a_srsel_write: assert property (
    wr_take && AVS_REQ.byteenable[0]
      && AVS_REQ.address == `CFCELL_OFF_SRSEL
      |=> st_ff.srsel == $past(AVS_REQ.writedata[`CFCELL_NSR-1:0]))
    else $error("set/reset select write did not land");
  a_init_write: assert property (
    wr_take && AVS_REQ.byteenable[0] && AVS_REQ.address == `CFCELL_OFF_INIT
      |=> st_ff.init == $past(AVS_REQ.writedata[`CFCELL_NCELL-1:0]))
    else $error("initial-state write did not land");
  a_table_write: assert property (
    wr_take && AVS_REQ.byteenable[0] && AVS_REQ.byteenable[1]
      && AVS_REQ.address == `CFCELL_OFF_TABLE
      |=> st_ff.table_word == $past(AVS_REQ.writedata[`CFCELL_TW-1:0]))
    else $error("table word write did not land");

  // A lane left out keeps its old byte
  a_table_lane: assert property (
    wr_take && !AVS_REQ.byteenable[1]
      && AVS_REQ.address == `CFCELL_OFF_TABLE
      |=> st_ff.table_word[`CFCELL_TW-1:`CFCELL_BYTE]
        == $past(st_ff.table_word[`CFCELL_TW-1:`CFCELL_BYTE]))
    else $error("table byte without its lane changed");

  // Read-only and unmapped offsets must not touch the configuration
  a_ro_ignore: assert property (
    wr_take && (AVS_REQ.address == `CFCELL_OFF_STATUS
      || AVS_REQ.address >= `CFCELL_OFF_STORED)
      |=> $stable(st_ff.mode) && $stable(st_ff.pol) && $stable(st_ff.srsel)
        && $stable(st_ff.init) && $stable(st_ff.table_word))
    else $error("write to a read-only offset changed the configuration");

  // Configuration moves only on an accepted write
  a_cfg_hold: assert property (
    !wr_take
      |=> $stable(st_ff.mode) && $stable(st_ff.pol) && $stable(st_ff.srsel)
        && $stable(st_ff.init) && $stable(st_ff.table_word))
    else $error("configuration changed without a write");

  // Read data stands until the next read is taken
  a_rdata_hold: assert property (
    !rd_load |=> $stable(AVS_READDATA))
    else $error("read data moved without a read");

  // The handshake never lingers in its answer state
  a_ack_once: assert property (
    st_ff.bus == cfcell_pkg::BUS_ACK |=> st_ff.bus == cfcell_pkg::BUS_IDLE)
    else $error("bus stayed in the answer state");
  a_bus_onehot: assert property (
    $onehot(st_ff.bus))
    else $error("bus state code is not one-hot");

  // Status and stored-value reads carry the flop contents
  a_stat_read: assert property (
    rd_load && AVS_REQ.address == `CFCELL_OFF_STATUS
      |=> AVS_READDATA[`CFCELL_STAT_TBIT] == $past(st_ff.table_out)
        && AVS_READDATA[`CFCELL_NCELL-1:0] == $past(st_ff.out))
    else $error("status read does not match the outputs");
  a_stored_read: assert property (
    rd_load && AVS_REQ.address == `CFCELL_OFF_STORED
      |=> AVS_READDATA == `CFCELL_DW'($past(cell_stored)))
    else $error("stored-value read does not match the cells");

  // Reset checks run with reset high, so reset must not disable them
  a_por_rdata: assert property (
    disable iff (1'b0) SRST |=> AVS_READDATA == '0)
    else $error("read data not cleared by reset");
  a_por_cfg: assert property (
    disable iff (1'b0) SRST
      |=> st_ff.pol == POL_DEFAULT && st_ff.srsel == SRSEL_DEFAULT
        && st_ff.table_word == TABLE_DEFAULT
        && st_ff.bus == cfcell_pkg::BUS_IDLE)
    else $error("reset did not reload the configuration");

endmodule

`default_nettype wire

// file: inc/cfcell_cfg.svh
/*
  Constants of the configurable storage cell block: counts, widths,
  register offsets, field positions and reset values.
  Assumes it is included by bare name from inc/ before any use.
*/
// How it works
// - A cell with its mode bit 0 is an edge-triggered flip-flop; with 1 it is a transparent latch.
// - A cell drives its stored value when its polarity bit is 0 and the inverted value when it is 1.
// - In cells 6 to 8 a set-reset select of 0 makes the asserted control input clear the stored value.
// - In cells 6 to 8 a set-reset select of 1 makes the asserted control input set the stored value.
// - While power-on reset is active each cell holds the value of its initial-state bit.
`ifndef CFCELL_CFG_SVH
`define CFCELL_CFG_SVH

// Cell counts and widths
`define CFCELL_NCELL 6
`define CFCELL_NSR 3
`define CFCELL_TW 16
`define CFCELL_SW 4
`define CFCELL_AW 8
`define CFCELL_DW 32
`define CFCELL_BEW 4
`define CFCELL_BYTE 8

// Register byte offsets
`define CFCELL_OFF_TABLE 8'h00
`define CFCELL_OFF_MODE 8'h04
`define CFCELL_OFF_POL 8'h08
`define CFCELL_OFF_SRSEL 8'h0c
`define CFCELL_OFF_INIT 8'h10
`define CFCELL_OFF_STATUS 8'h14
`define CFCELL_OFF_STORED 8'h18

// Status field position of the table output
`define CFCELL_STAT_TBIT 8

// Reset values of the configuration registers
`define CFCELL_RST_TABLE 16'h0000
`define CFCELL_RST_MODE 6'h00
`define CFCELL_RST_POL 6'h00
`define CFCELL_RST_SRSEL 3'h0
`define CFCELL_RST_INIT 6'h00

`endif

// file: inc/cfcell_pkg.sv
/*
  Types of the configurable storage cell block.
  Assumes cfcell_cfg.svh is on the include path.
*/
`default_nettype none
`include "cfcell_cfg.svh"

package cfcell_pkg;

  // Bus handshake states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } cfcell_bus_t;

  // Configuration of one storage cell
  typedef struct packed {
    logic mode;
    logic pol;
    logic srsel;
    logic init;
  } cfcell_cellcfg_t;

  // State of one storage cell
  typedef struct packed {
    logic q;
    logic gate_prev;
  } cfcell_cellst_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [`CFCELL_AW-1:0] address;
    logic [`CFCELL_BEW-1:0] byteenable;
    logic [`CFCELL_DW-1:0] writedata;
  } cfcell_avreq_t;

  // State of the top level
  typedef struct packed {
    cfcell_bus_t bus;
    logic [`CFCELL_TW-1:0] table_word;
    logic [`CFCELL_NCELL-1:0] mode;
    logic [`CFCELL_NCELL-1:0] pol;
    logic [`CFCELL_NSR-1:0] srsel;
    logic [`CFCELL_NCELL-1:0] init;
    logic [`CFCELL_DW-1:0] rdata;
    logic [`CFCELL_NCELL-1:0] out;
    logic table_out;
  } cfcell_top_st_t;

endpackage

`default_nettype wire

// file: core/cfcell_table.sv
/*
  Four-input lookup table: one bit out of a sixteen-bit truth word.
  Assumes the truth word and the inputs are stable flop outputs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfcell_cfg.svh"

module cfcell_table (
  input wire logic [`CFCELL_TW-1:0] truth, // Truth-table word
  input wire logic [`CFCELL_SW-1:0] sel,   // Matrix inputs, bit 0 lowest
  output logic pick                        // Selected bit
);

  // Inputs form the index into the word
  assign pick = truth[sel];

endmodule

`default_nettype wire

// file: core/cfcell_cell.sv
/*
  One storage cell: flip-flop or transparent latch on a matrix gate,
  optional matrix set-or-reset, output polarity, power-on value.
  Assumes gate, data and control are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfcell_cfg.svh"

module cfcell_cell #(
  parameter bit HAS_SR = 1'b0 // Cell has the matrix set/reset input
) (
  input wire logic clk,                      // System clock
  input wire logic rst,                      // Power-on reset, high
  input wire cfcell_pkg::cfcell_cellcfg_t cfg, // Cell configuration
  input wire logic d,                        // Matrix data
  input wire logic gate,                     // Matrix clock or enable
  input wire logic sr,                       // Matrix set/reset, high
  output logic stored,                       // Stored value
  output logic drive                         // Value toward the matrix
);

  cfcell_pkg::cfcell_cellst_t st_ff, nxt_st;
  logic sr_hit;

  // Next state; reset beats set/reset, which beats data
  always_comb begin
    nxt_st = st_ff;
    nxt_st.gate_prev = gate;
    sr_hit = HAS_SR && sr;
    if (rst) begin
      nxt_st.q = cfg.init;
    end else if (sr_hit) begin
      nxt_st.q = cfg.srsel;
    end else if (cfg.mode) begin
      if (gate) begin
        nxt_st.q = d;
      end
    end else if (gate && !st_ff.gate_prev) begin
      nxt_st.q = d;
    end
  end

  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
  end

  // Gate rise is seen on the edge that first samples gate high, and data lands on that edge
  assign stored = st_ff.q;
  assign drive = st_ff.q ^ cfg.pol;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_rise;
    !cfg.mode && !sr_hit && gate && !st_ff.gate_prev;
  endsequence

  a_ff_rise_load: assert property (
    s_rise |=> stored == $past(d))
    else $error("flip-flop missed data on gate rise");
  a_ff_hold: assert property (
    !cfg.mode && !sr_hit && !(gate && !st_ff.gate_prev) |=> $stable(stored))
    else $error("flip-flop changed without gate rise");
  a_latch_pass: assert property (
    cfg.mode && !sr_hit && gate |=> stored == $past(d))
    else $error("open latch did not follow data");
  a_latch_hold: assert property (
    cfg.mode && !sr_hit && !gate |=> $stable(stored))
    else $error("closed latch changed");
  a_sr_clear: assert property (
    sr_hit && !cfg.srsel |=> !stored)
    else $error("reset by matrix did not clear");
  a_sr_set: assert property (
    sr_hit && cfg.srsel |=> stored)
    else $error("set by matrix did not set");
  a_por_init: assert property (
    $fell(rst) |-> stored == $past(cfg.init))
    else $error("cell left reset without its initial value");

endmodule

`default_nettype wire

// file: test/cfcell_matrix.sv
/*
  Routing matrix model: drives the cell data, gate, set/reset and
  table inputs one clock after the bench asks, like a matrix flop.
  Assumes requests change right after a rising edge of clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfcell_cfg.svh"

module cfcell_matrix (
  input wire logic clk, // System clock
  input wire logic [`CFCELL_NCELL-1:0] want_data, // Requested data
  input wire logic [`CFCELL_NCELL-1:0] want_gate, // Requested gate
  input wire logic [`CFCELL_NSR-1:0] want_sr, // Requested set/reset
  input wire logic [`CFCELL_SW-1:0] want_sel, // Requested table index
  output logic [`CFCELL_NCELL-1:0] data = '0, // To cell data
  output logic [`CFCELL_NCELL-1:0] gate = '0, // To cell gate
  output logic [`CFCELL_NSR-1:0] sr = '0, // To cell set/reset
  output logic [`CFCELL_SW-1:0] sel = '0 // To table inputs
);
  // One stage, so nets never move near the sampling edge
  always @(posedge clk) begin
    data <= want_data;
    gate <= want_gate;
    sr <= want_sr;
    sel <= want_sel;
  end
endmodule

`default_nettype wire

// file: test/test_cfcell_top.sv
/*
  Self-checking bench of the storage cells and the table: registers
  over Avalon-MM, matrix nets through the matrix model.
  Assumes cell outputs answer three edges and the table two edges after a matrix step.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfcell_cfg.svh"

module test_cfcell_top;
  localparam logic [5:0] INIT = 6'h2d;
  logic clk = 1'b0;
  logic srst = 1'b1;
  cfcell_pkg::cfcell_avreq_t req = '0;
  logic [31:0] rdata;
  logic [31:0] got;
  logic wait_r;
  logic t_out;
  logic [5:0] m_data = '0;
  logic [5:0] m_gate = '0;
  logic [2:0] m_sr = '0;
  logic [3:0] m_sel = '0;
  logic [5:0] x_data;
  logic [5:0] x_gate;
  logic [2:0] x_sr;
  logic [3:0] x_sel;
  logic [5:0] cell_out;
  logic [15:0] word = 16'h6a5c;
  int error_cnt = 0;
  int tests_run = 0;
  int cycles = 0;

  // 25 MHz system clock
  always #20 clk = ~clk;

  cfcell_top #(.INIT_DEFAULT(INIT)) u_dut (
    .CLK_SYS(clk), .SRST(srst), .AVS_REQ(req), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_r), .CELL_DATA(x_data), .CELL_GATE(x_gate),
    .CELL_SR(x_sr), .CELL_OUT(cell_out),
    .FOUR_INPUT_TABLE_ONE_IN(x_sel), .FOUR_INPUT_TABLE_ONE_OUT(t_out));

  cfcell_matrix u_mx (
    .clk(clk), .want_data(m_data), .want_gate(m_gate), .want_sr(m_sr),
    .want_sel(m_sel), .data(x_data), .gate(x_gate), .sr(x_sr),
    .sel(x_sel));

  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Register values
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  // Matrix-side pin values
  task automatic chk_pin(input logic [5:0] g, input logic [5:0] e);
    chk_reg({26'h0, g}, {26'h0, e});
  endtask

  // Request held until waitrequest is seen low at an edge
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] be);
    @(posedge clk);
    req <= '{read: 1'b0, write: 1'b1, address: a, byteenable: be,
             writedata: d};
    @(posedge clk iff wait_r === 1'b0);
    req <= '0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    req <= '{read: 1'b1, write: 1'b0, address: a, byteenable: 4'hf,
             writedata: 32'h0};
    @(posedge clk iff wait_r === 1'b0);
    got = rdata;
    req <= '0;
    chk_reg(got, e);
  endtask

  // Matrix step: model stage, cell, output flop, then sample
  task automatic mx(input logic [5:0] d, input logic [5:0] g,
                    input logic [2:0] s, input logic [3:0] t);
    @(posedge clk);
    m_data <= d;
    m_gate <= g;
    m_sr <= s;
    m_sel <= t;
    repeat (4) @(posedge clk);
  endtask

  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    repeat (7) @(posedge clk);
    chk_pin(cell_out, INIT);
    @(posedge clk);
    srst <= 1'b0;
    rd_chk(`CFCELL_OFF_MODE, 32'h0);
    rd_chk(`CFCELL_OFF_INIT, {26'h0, INIT});
    rd_chk(8'h40, 32'h0);
    bus_wr(`CFCELL_OFF_STATUS, 32'hffffffff, 4'hf);
    rd_chk(`CFCELL_OFF_STATUS, {26'h0, INIT});
    // Flip-flop: only a gate rise loads data
    mx(6'h3f, 6'h00, 3'h0, 4'h0);
    mx(6'h3f, 6'h3f, 3'h0, 4'h0);
    chk_pin(cell_out, 6'h3f);
    mx(6'h00, 6'h3f, 3'h0, 4'h0);
    chk_pin(cell_out, 6'h3f);
    mx(6'h00, 6'h00, 3'h0, 4'h0);
    mx(6'h00, 6'h3f, 3'h0, 4'h0);
    chk_pin(cell_out, 6'h00);
    // Latch: transparent while gate high, holds while low
    bus_wr(`CFCELL_OFF_MODE, 32'h3f, 4'hf);
    mx(6'h3f, 6'h3f, 3'h0, 4'h0);
    chk_pin(cell_out, 6'h3f);
    mx(6'h00, 6'h3f, 3'h0, 4'h0);
    chk_pin(cell_out, 6'h00);
    mx(6'h00, 6'h00, 3'h0, 4'h0);
    mx(6'h3f, 6'h00, 3'h0, 4'h0);
    chk_pin(cell_out, 6'h00);
    // Mixed polarity per cell
    bus_wr(`CFCELL_OFF_POL, 32'h15, 4'hf);
    mx(6'h3f, 6'h00, 3'h0, 4'h0);
    chk_pin(cell_out, 6'h15);
    rd_chk(`CFCELL_OFF_STORED, 32'h0);
    // Set/reset overrides data of the opposite value
    bus_wr(`CFCELL_OFF_SRSEL, 32'h5, 4'hf);
    mx(6'h00, 6'h3f, 3'h7, 4'h0);
    rd_chk(`CFCELL_OFF_STORED, 32'h05);
    mx(6'h3f, 6'h3f, 3'h7, 4'h0);
    rd_chk(`CFCELL_OFF_STORED, 32'h3d);
    bus_wr(`CFCELL_OFF_SRSEL, 32'h2, 4'hf);
    mx(6'h00, 6'h3f, 3'h7, 4'h0);
    rd_chk(`CFCELL_OFF_STORED, 32'h02);
    chk_pin(cell_out, 6'h17);
    // Every table index
    bus_wr(`CFCELL_OFF_TABLE, {16'h0, word}, 4'h3);
    for (int i = 0; i < 16; i++) begin
      mx(6'h00, 6'h3f, 3'h0, i[3:0]);
      chk_pin({5'h0, t_out}, {5'h0, word[i]});
    end
    // Table bit and outputs also show in the status word
    mx(6'h00, 6'h3f, 3'h0, 4'h2);
    rd_chk(`CFCELL_OFF_STATUS, 32'h115);
    // Low lane only
    bus_wr(`CFCELL_OFF_TABLE, 32'hffff, 4'h1);
    rd_chk(`CFCELL_OFF_TABLE, 32'h6aff);
    // A written initial state is replaced by the default at reset
    bus_wr(`CFCELL_OFF_INIT, 32'h12, 4'h1);
    rd_chk(`CFCELL_OFF_INIT, 32'h12);
    // Second reset in mid-run reloads the initial states
    @(posedge clk);
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    chk_pin(cell_out, INIT);
    srst <= 1'b0;
    rd_chk(`CFCELL_OFF_MODE, 32'h0);
    rd_chk(`CFCELL_OFF_INIT, {26'h0, INIT});
    test_done();
  end
endmodule

`default_nettype wire
